/* logic/lpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_top
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Printer mechanism
    input wire lpc_pkg::lpc_pins_s pins_in,
    output lpc_pkg::lpc_prt_s prt,
    // Interrupt
    output logic irq
);
    //==========================================================
    // Bit access with bit 0 as the most significant bit.
    function automatic logic wbit(input logic [15:0] w, input int n);
        return w[15 - n];
    endfunction

    //==========================================================
    // Pin synchronisers
    logic [lpc_pkg::PINS_W-1:0] pins_bits;
    lpc_pkg::lpc_pins_s pq;
    lpc_sync #(.W(lpc_pkg::PINS_W)) u_sync
    (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .d(pins_in),
        .q(pins_bits)
    );
    assign pq = lpc_pkg::lpc_pins_s'(pins_bits);

    //==========================================================
    // State
    lpc_pkg::lpc_buf_e bst_reg, bst_next;
    lpc_pkg::lpc_pap_e pst_reg, pst_next;
    logic [6:0] ptr_reg, ptr_next, idx_reg, idx_next;
    logic fill_reg, fill_next, pend_reg, pend_next;
    logic [2:0] tgt_reg, tgt_next;
    logic [7:0] cnt_reg, cnt_next;
    logic single_reg, single_next;
    logic [15:0] tw_reg;
    logic [3:0] ev_reg, ev_next, mask_reg;
    logic par_d_reg, ev_buf, ev_pap;
    lpc_pkg::lpc_prt_s prt_next;
    logic [7:0] line_mem [0:lpc_pkg::LINE_LEN-1];

    //==========================================================
    // Bus decode
    wire acc = psel & penable;
    wire take = acc & pready & ce;
    wire wr_take = take & pwrite;
    wire hit_ctrl = paddr == lpc_pkg::A_CTRL;
    wire hit_data = paddr == lpc_pkg::A_DATA;
    wire hit_test = paddr == lpc_pkg::A_TEST;
    wire hit_cond = paddr == lpc_pkg::A_COND;
    wire hit_ev = paddr == lpc_pkg::A_EVENT;
    wire hit_mask = paddr == lpc_pkg::A_MASK;
    wire mapped = hit_ctrl | hit_data | hit_test | hit_cond | hit_ev | hit_mask;
    wire ctrl_go = (bst_reg == lpc_pkg::B_IDLE) & (pst_reg == lpc_pkg::P_IDLE);
    wire buf_full = fill_reg & (ptr_reg == lpc_pkg::LINE_FULL);
    // A full buffer never answers, so the master hangs as the host expects.
    wire data_go = (bst_reg == lpc_pkg::B_IDLE) & ~buf_full;
    wire go = hit_ctrl ? ctrl_go : (hit_data ? data_go : 1'b1);

    //==========================================================
    // Control word decode
    wire [15:0] cw = pwdata[15:0];
    wire ctrl_take = wr_take & hit_ctrl;
    wire c_chan = wbit(cw, lpc_pkg::CW_CHAN);
    wire c_fill = wbit(cw, lpc_pkg::CW_FILL) & ~c_chan;
    wire c_clear = wbit(cw, lpc_pkg::CW_CLEAR);
    wire c_print = wbit(cw, lpc_pkg::CW_PRINT);
    wire c_tof = wbit(cw, lpc_pkg::CW_TOF);
    wire c_adv1 = wbit(cw, lpc_pkg::CW_ADV1);
    wire [2:0] c_n = cw[lpc_pkg::CW_N_W-1:0];
    wire [2:0] mech_cnt = 3'(c_print) + 3'(c_tof) + 3'(c_adv1) + 3'(c_chan);
    wire c_chan_extra = c_chan & (c_clear | c_print | c_tof | c_adv1);
    wire conflict = (mech_cnt > 3'h1) | (c_clear & c_fill) | c_chan_extra;
    // Compatible bits start in the same cycle, except that a print waits for a clear and fill is dropped with a channel select.
    wire cmd_go = ctrl_take & ~conflict;
    wire data_store = wr_take & hit_data & fill_reg & ~buf_full;

    //==========================================================
    // Status test
    wire busy_any = pq.busy | ~ctrl_go;
    wire sel_ok_inop = ~(wbit(tw_reg, lpc_pkg::TW_INOP) & pq.inop);
    wire sel_ok_bof = ~(wbit(tw_reg, lpc_pkg::TW_BOF) & pq.bof);
    wire sel_ok_par = ~(wbit(tw_reg, lpc_pkg::TW_PAR) & pq.parity);
    wire sel_ok_busy = ~(wbit(tw_reg, lpc_pkg::TW_BUSY) & busy_any);
    // One failing condition is enough to suppress the skip.
    wire skip = sel_ok_inop & sel_ok_bof & sel_ok_par & sel_ok_busy;

    //==========================================================
    // Read mux
    wire [31:0] rd_test = {15'h0000, skip, tw_reg};
    wire [31:0] rd_cond = {16'h0000, ptr_reg, fill_reg, bst_reg, pst_reg,
                           pq.inop, pq.bof, pq.parity, busy_any};
    wire [31:0] rd_mux = hit_test ? rd_test :
                         hit_cond ? rd_cond :
                         hit_ev ? {28'h0000000, ev_reg} :
                         hit_mask ? {28'h0000000, mask_reg} : 32'h00000000;

    //==========================================================
    // Buffer engine
    always_comb
    begin
        bst_next = bst_reg;
        idx_next = idx_reg;
        ptr_next = ptr_reg;
        fill_next = fill_reg;
        pend_next = pend_reg;
        ev_buf = 1'b0;
        prt_next = '0;
        prt_next.feed = pst_reg == lpc_pkg::P_STEP;
        if (data_store)
        begin
            ptr_next = ptr_reg + 7'h01;
        end
        case (bst_reg)
            lpc_pkg::B_IDLE:
            begin
                if (cmd_go & c_fill)
                begin
                    fill_next = 1'b1;
                    ptr_next = 7'h00;
                end
                if (cmd_go & c_clear)
                begin
                    bst_next = lpc_pkg::B_CLEAR;
                    idx_next = 7'h00;
                    ptr_next = 7'h00;
                    pend_next = c_print;
                end
                else if (cmd_go & c_print)
                begin
                    bst_next = lpc_pkg::B_PRINT;
                    idx_next = 7'h00;
                end
            end
            lpc_pkg::B_CLEAR:
            begin
                idx_next = idx_reg + 7'h01;
                if (idx_reg == lpc_pkg::LINE_LAST)
                begin
                    idx_next = 7'h00;
                    pend_next = 1'b0;
                    bst_next = pend_reg ? lpc_pkg::B_PRINT : lpc_pkg::B_IDLE;
                end
            end
            lpc_pkg::B_PRINT:
            begin
                prt_next.strobe = 1'b1;
                prt_next.code = line_mem[idx_reg];
                idx_next = idx_reg + 7'h01;
                if (idx_reg == lpc_pkg::LINE_LAST)
                begin
                    idx_next = 7'h00;
                    prt_next.fire = 1'b1;
                    ev_buf = 1'b1;
                    bst_next = lpc_pkg::B_IDLE;
                end
            end
            default:
            begin
                bst_next = lpc_pkg::B_IDLE;
            end
        endcase
    end

    // Clearing takes one cycle a position; data and control writes in that time are stalled.
    wire mem_we = (bst_reg == lpc_pkg::B_CLEAR) | data_store;
    wire [6:0] mem_wa = (bst_reg == lpc_pkg::B_CLEAR) ? idx_reg : ptr_reg;
    wire [7:0] mem_wd = (bst_reg == lpc_pkg::B_CLEAR) ? lpc_pkg::SPACE_CODE
                                                       : pwdata[7:0];

    always_ff @(posedge pclk)
    begin
        if (ce & mem_we)
        begin
            line_mem[mem_wa] <= mem_wd;
        end
    end

    //==========================================================
    // Paper engine
    always_comb
    begin
        pst_next = pst_reg;
        tgt_next = tgt_reg;
        cnt_next = cnt_reg;
        single_next = single_reg;
        ev_pap = 1'b0;
        case (pst_reg)
            lpc_pkg::P_IDLE:
            begin
                if (cmd_go & (c_adv1 | c_chan | c_tof))
                begin
                    pst_next = lpc_pkg::P_STEP;
                    single_next = c_adv1;
                    tgt_next = c_chan ? c_n : 3'h0;
                end
            end
            lpc_pkg::P_STEP:
            begin
                pst_next = lpc_pkg::P_SETTLE;
                cnt_next = lpc_pkg::STEP_CYC_W;
            end
            lpc_pkg::P_SETTLE:
            begin
                if (cnt_reg != 8'h00)
                begin
                    cnt_next = cnt_reg - 8'h01;
                end
                else if (single_reg | pq.punch[tgt_reg])
                begin
                    pst_next = lpc_pkg::P_IDLE;
                    ev_pap = 1'b1;
                end
                else
                begin
                    pst_next = lpc_pkg::P_STEP;
                end
            end
            default:
            begin
                pst_next = lpc_pkg::P_IDLE;
            end
        endcase
    end

    //==========================================================
    // Events and interrupt
    wire [3:0] ev_set = {pq.parity & ~par_d_reg, ev_pap, ev_buf, ctrl_take & conflict};
    wire [3:0] ev_clr = (wr_take & hit_ev) ? pwdata[3:0] : 4'h0;
    // A new event in the clearing cycle survives the clear.
    assign ev_next = (ev_reg & ~ev_clr) | ev_set;

    //==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bst_reg <= lpc_pkg::B_IDLE;
            pst_reg <= lpc_pkg::P_IDLE;
            ptr_reg <= 7'h00;
            idx_reg <= 7'h00;
            fill_reg <= 1'b0;
            pend_reg <= 1'b0;
            tgt_reg <= 3'h0;
            cnt_reg <= 8'h00;
            single_reg <= 1'b0;
            prt <= '0;
        end
        else if (ce)
        begin
            bst_reg <= bst_next;
            pst_reg <= pst_next;
            ptr_reg <= ptr_next;
            idx_reg <= idx_next;
            fill_reg <= fill_next;
            pend_reg <= pend_next;
            tgt_reg <= tgt_next;
            cnt_reg <= cnt_next;
            single_reg <= single_next;
            prt <= prt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            tw_reg <= 16'h0000;
            ev_reg <= lpc_pkg::EV_RESET;
            mask_reg <= lpc_pkg::MASK_RESET;
            par_d_reg <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            pready <= acc & ~pready & go;
            if (acc & ~pready & go)
            begin
                prdata <= rd_mux;
                pslverr <= ~mapped;
            end
            if (wr_take & hit_test)
            begin
                tw_reg <= cw;
            end
            if (wr_take & hit_mask)
            begin
                mask_reg <= pwdata[3:0];
            end
            ev_reg <= ev_next;
            par_d_reg <= pq.parity;
            irq <= |(ev_next & mask_reg);
        end
    end

    //==========================================================
    // Assertions
    a_fill_entry: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go & c_fill |=> fill_reg && ptr_reg == 7'h00)
        else $error("fill command did not open the buffer");
    a_fmt_nofill: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go & c_chan |=> fill_reg == $past(fill_reg) && pst_reg == lpc_pkg::P_STEP)
        else $error("channel select changed fill mode or did not move paper");
    a_adv_one: assert property (@(posedge pclk) disable iff (!presetn)
        ce && pst_reg == lpc_pkg::P_SETTLE && cnt_reg == 8'h00 && single_reg
        |=> pst_reg == lpc_pkg::P_IDLE)
        else $error("single line advance took more than one step");
    a_chan_pick: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go & c_chan |=> tgt_reg == $past(c_n))
        else $error("wrong format channel selected");
    a_tof_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go & (c_tof | (c_chan & c_n == 3'h0)) |=> tgt_reg == 3'h0)
        else $error("top of form not routed to channel zero");
    a_punch_wait: assert property (@(posedge pclk) disable iff (!presetn)
        ce && pst_reg == lpc_pkg::P_SETTLE && cnt_reg == 8'h00 && !single_reg
        && !pq.punch[tgt_reg] |=> pst_reg == lpc_pkg::P_STEP)
        else $error("paper stopped before channel punch");
    a_fill_order: assert property (@(posedge pclk) disable iff (!presetn)
        data_store |=> ptr_reg == $past(ptr_reg) + 7'h01
        && line_mem[$past(ptr_reg)] == $past(pwdata[7:0]))
        else $error("character not stored in order");
    a_clear_space: assert property (@(posedge pclk) disable iff (!presetn)
        ce && bst_reg == lpc_pkg::B_CLEAR |=> line_mem[$past(idx_reg)] == lpc_pkg::SPACE_CODE)
        else $error("clear did not write a space");
    a_full_stall: assert property (@(posedge pclk) disable iff (!presetn)
        acc && hit_data && buf_full |-> !pready ##1 !pready)
        else $error("full buffer answered a character");
    a_multi_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go & c_clear & c_adv1 |=> bst_reg == lpc_pkg::B_CLEAR && pst_reg == lpc_pkg::P_STEP)
        else $error("compatible commands not run together");
    a_skip_fail: assert property (@(posedge pclk) disable iff (!presetn)
        wbit(tw_reg, lpc_pkg::TW_BUSY) && busy_any |-> !rd_test[lpc_pkg::TEST_SKIP_POS])
        else $error("skip granted while busy");
    a_conflict_none: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_take & conflict |=> bst_reg == lpc_pkg::B_IDLE && pst_reg == lpc_pkg::P_IDLE
        && ptr_reg == $past(ptr_reg) && ev_reg[lpc_pkg::EV_CONFLICT])
        else $error("conflicting command had an effect");

    c_clear_print: cover property (@(posedge pclk) disable iff (!presetn)
        cmd_go & c_clear & c_print);
    c_line_done: cover property (@(posedge pclk) disable iff (!presetn) prt.fire);
    c_full_wait: cover property (@(posedge pclk) disable iff (!presetn) acc & hit_data & buf_full);
    c_conflict: cover property (@(posedge pclk) disable iff (!presetn) ctrl_take & conflict);
endmodule // lpc_top
`default_nettype wire

/* logic/lpc_pkg.sv */
//==============================================================
//==============================================================
`default_nettype none
package lpc_pkg;
    //==========================================================
    // Timing
    localparam int CLK_NS = 8;
    localparam int LINE_STEP_NS = 1000;
    localparam int STEP_CYC = (LINE_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] STEP_CYC_W = 8'(STEP_CYC);
    //==========================================================
    // Line buffer
    localparam int LINE_LEN = 120;
    localparam logic [6:0] LINE_LAST = 7'(LINE_LEN - 1);
    localparam logic [6:0] LINE_FULL = 7'(LINE_LEN);
    localparam logic [7:0] SPACE_CODE = 8'h20;
    //==========================================================
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_TEST = 8'h08;
    localparam logic [7:0] A_COND = 8'h0C;
    localparam logic [7:0] A_EVENT = 8'h10;
    localparam logic [7:0] A_MASK = 8'h14;
    //==========================================================
    // Control word bits, numbered from the most significant end
    localparam int CW_FILL = 9;
    localparam int CW_CLEAR = 8;
    localparam int CW_PRINT = 7;
    localparam int CW_TOF = 6;
    localparam int CW_ADV1 = 5;
    localparam int CW_CHAN = 4;
    localparam int CW_N_W = 3;
    //==========================================================
    // Test word bits, numbered from the most significant end
    localparam int TW_INOP = 9;
    localparam int TW_BOF = 8;
    localparam int TW_PAR = 6;
    localparam int TW_BUSY = 4;
    localparam int TEST_SKIP_POS = 16;
    //==========================================================
    // Event bits
    localparam int EV_CONFLICT = 0;
    localparam int EV_PRINT = 1;
    localparam int EV_PAPER = 2;
    localparam int EV_PARITY = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] EV_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    //==========================================================
    // Types
    typedef struct packed {
        logic inop;
        logic bof;
        logic parity;
        logic busy;
        logic [7:0] punch;
    } lpc_pins_s;
    localparam int PINS_W = 12;
    typedef struct packed {
        logic strobe;
        logic [7:0] code;
        logic fire;
        logic feed;
    } lpc_prt_s;
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_CLEAR = 2'b01,
        B_PRINT = 2'b10
    } lpc_buf_e;
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_STEP = 2'b01,
        P_SETTLE = 2'b10
    } lpc_pap_e;
endpackage
`default_nettype wire

/* logic/lpc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_sync #(parameter int W = 12)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_reg[i] <= 1'b0;
                    q[i] <= 1'b0;
                end
                else if (ce)
                begin
                    s1_reg[i] <= d[i];
                    q[i] <= s1_reg[i];
                end
            end
        end
    endgenerate
endmodule // lpc_sync
`default_nettype wire

/* bench/lpc_printer.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_printer #(parameter int FORM = 6)
(
    // Clock
    input wire logic pclk,
    // Mechanism side
    input wire lpc_pkg::lpc_prt_s prt,
    input wire logic [3:0] stat,
    output var lpc_pkg::lpc_pins_s pins
);
    //==========================================================
    // Paper, hammers and format loop
    // Paper position survives a controller reset, as real paper would.
    int line = 1;
    int feeds = 0;
    int strobes = 0;
    int fires = 0;
    int idx = 0;
    logic [7:0] got [0:119];
    always @(posedge pclk)
    begin
        if (prt.feed)
        begin
            line <= line + 1;
            feeds <= feeds + 1;
        end
        if (prt.strobe)
        begin
            got[idx] <= prt.code;
            idx <= prt.fire ? 0 : idx + 1;
            strobes <= strobes + 1;
        end
        if (prt.fire)
            fires <= fires + 1;
    end
    // Channel 0 is punched once a form, channel n every n+2 lines.
    always_comb
    begin
        pins.inop = stat[3];
        pins.bof = stat[2];
        pins.parity = stat[1];
        pins.busy = stat[0];
        for (int n = 0; n < 8; n++)
            pins.punch[n] = (line % ((n == 0) ? FORM : n + 2)) == 0;
    end
endmodule // lpc_printer
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    //==========================================================
    // Signals
    localparam int FORM = 6;
    logic pclk = 0;
    logic presetn = 0;
    logic ce = 1'b1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] stat = 4'h0;
    lpc_pkg::lpc_pins_s pins;
    lpc_pkg::lpc_prt_s prt;
    logic [31:0] rd;
    logic [31:0] tw;
    logic [3:0] sel;
    logic err;
    logic got;
    logic [7:0] expl [0:119];
    logic [31:0] bad [0:3] = '{32'h500, 32'hC0, 32'hA00, 32'h900};
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int f0;
    int s0;
    int k;
    int seed;
    lpc_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pins), .prt(prt), .irq(irq));
    lpc_printer #(.FORM(FORM)) u_prt (.pclk(pclk), .prt(prt), .stat(stat), .pins(pins));
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    //==========================================================
    // Tasks
    task automatic stop_test();
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input int lim);
        int n;
        n = 0;
        got = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (!got && n < lim)
        begin
            @(posedge pclk);
            n++;
            got = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (lim > 300)
            chk("pready", 32'h1, {31'h0, got});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 3000);
    endtask
    task automatic idle();
        int n;
        n = 0;
        rd = 32'hF0;
        while (rd[7:4] !== 4'h0 && n < 3000)
        begin
            apb(1'b0, lpc_pkg::A_COND, 32'h0, 3000);
            n++;
        end
    endtask
    // Bit 0 of a control or test word is the most significant of sixteen.
    function automatic logic [31:0] cw(input int b);
        return 32'h1 << (15 - b);
    endfunction
    function automatic int steps(input int l, input int n);
        int m;
        int s;
        m = (n == 0) ? FORM : n + 2;
        s = 1;
        while ((l + s) % m != 0)
            s++;
        return s;
    endfunction
    task automatic fill(input int n);
        wr(lpc_pkg::A_CTRL, cw(lpc_pkg::CW_FILL));
        for (int i = 0; i < 120; i++)
        begin
            expl[i] = (i < n) ? 8'(8'h21 + $urandom % 94) : lpc_pkg::SPACE_CODE;
            if (i < n)
                wr(lpc_pkg::A_DATA, {24'h0, expl[i]});
        end
    endtask
    task automatic print_chk();
        s0 = u_prt.strobes;
        f0 = u_prt.fires;
        wr(lpc_pkg::A_EVENT, 32'hF);
        wr(lpc_pkg::A_CTRL, cw(lpc_pkg::CW_PRINT));
        idle();
        chk("strobes", 32'h78, 32'(u_prt.strobes - s0));
        chk("fires", 32'h1, 32'(u_prt.fires - f0));
        for (int i = 0; i < 120; i++)
            chk("char", {24'h0, expl[i]}, {24'h0, u_prt.got[i]});
        // Only the print done event may stand after a clean print.
        apb(1'b0, lpc_pkg::A_EVENT, 32'h0, 3000);
        chk("events", 32'h2, rd);
    endtask
    //==========================================================
    // Timeout and main sequence
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            errors++;
            $display("mismatch timeout expected %h seen %h", 0, cyc);
            stop_test();
        end
    end
    initial
    begin
        seed = $urandom(64540);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wr(lpc_pkg::A_CTRL, cw(lpc_pkg::CW_CLEAR));
        fill(1 + $urandom % 119);
        print_chk();
        fill(120);
        print_chk();
        apb(1'b1, lpc_pkg::A_DATA, 32'h41, 300);
        chk("reply", 32'h0, {31'h0, got});
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        f0 = u_prt.feeds;
        k = steps(u_prt.line, 3);
        wr(lpc_pkg::A_CTRL, cw(lpc_pkg::CW_FILL) | cw(lpc_pkg::CW_CHAN) | 32'h3);
        idle();
        chk("fill", 32'h0, {31'h0, rd[8]});
        chk("feeds", 32'(k), 32'(u_prt.feeds - f0));
        f0 = u_prt.feeds;
        wr(lpc_pkg::A_CTRL, cw(lpc_pkg::CW_CLEAR) | cw(lpc_pkg::CW_ADV1));
        idle();
        chk("feeds", 32'h1, 32'(u_prt.feeds - f0));
        fill(0);
        print_chk();
        for (int n = -1; n < 8; n++)
        begin
            f0 = u_prt.feeds;
            k = steps(u_prt.line, (n < 0) ? 0 : n);
            wr(lpc_pkg::A_CTRL, (n < 0) ? cw(6) : cw(4) | 32'(n));
            idle();
            chk("feeds", 32'(k), 32'(u_prt.feeds - f0));
        end
        for (int i = 0; i < 4; i++)
        begin
            f0 = u_prt.feeds + u_prt.strobes;
            wr(lpc_pkg::A_EVENT, 32'hF);
            wr(lpc_pkg::A_CTRL, bad[i]);
            idle();
            chk("moved", 32'h0, 32'(u_prt.feeds + u_prt.strobes - f0));
            apb(1'b0, lpc_pkg::A_EVENT, 32'h0, 3000);
            chk("conflict", 32'h1, rd);
        end
        // The interrupt follows a mask change one cycle late and an event change in the same cycle.
        wr(lpc_pkg::A_MASK, 32'h1);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(lpc_pkg::A_MASK, 32'h0);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(lpc_pkg::A_MASK, 32'h1);
        wr(lpc_pkg::A_EVENT, 32'h1);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        // With the enable low the bus must not answer and no register may move.
        ce <= 1'b0;
        apb(1'b1, lpc_pkg::A_MASK, 32'hE, 20);
        chk("frozen", 32'h0, {31'h0, got});
        ce <= 1'b1;
        apb(1'b0, lpc_pkg::A_MASK, 32'h0, 3000);
        chk("mask", 32'h1, rd);
        repeat (8)
        begin
            stat <= 4'($urandom);
            sel = 4'($urandom);
            repeat (4) @(posedge pclk);
            tw = (sel[3] ? cw(9) : 0) | (sel[2] ? cw(8) : 0) | (sel[1] ? cw(6) : 0);
            tw = tw | (sel[0] ? cw(4) : 0);
            wr(lpc_pkg::A_TEST, tw);
            apb(1'b0, lpc_pkg::A_TEST, 32'h0, 3000);
            chk("test", {15'h0, (sel & stat) == 4'h0, tw[15:0]}, rd);
        end
        apb(1'b0, 8'h18, 32'h0, 3000);
        chk("slverr", 32'h1, {31'h0, err});
        chk("rdata", 32'h0, rd);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
